// File: src/fcs_pkg.sv
package fcs_pkg;

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int MEM_BYTES = 131072;
    localparam int SECTOR_COUNT = 8;
    localparam int SECTOR_BYTES = 16384;
    localparam int SECTOR_SEL_LSB = 14; // sector number sits above this

    // ----------------------------------------------------------------
    // status bits on the byte data bus during an operation
    // ----------------------------------------------------------------
    localparam int COMPLETION_POLL_POS = 7;
    localparam int TOGGLE_STATUS_POS = 6;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ----------------------------------------------------------------
    // timing at a 100 ns clock
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_ACCESS_NS = 100;  // worst read access assumed
    localparam int T_WE_LOW_NS = 100;  // least write strobe width
    localparam int ACC_CYC_RAW =
        (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC = (ACC_CYC_RAW < 1) ? 1 : ACC_CYC_RAW;
    localparam int WE_CYC_RAW =
        (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_CYC = (WE_CYC_RAW < 1) ? 1 : WE_CYC_RAW;
    localparam int SYNC_STAGES = 2;
    localparam int RD_CYC = ACC_CYC + SYNC_STAGES + 1;
    localparam int POLL_LIMIT_DEF = 200000;

    // ----------------------------------------------------------------
    // requests accepted on the user port
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FCS_OP_READ,
        FCS_OP_PROGRAM,
        FCS_OP_ERASE_SECTOR,
        FCS_OP_SUSPEND,
        FCS_OP_RESUME,
        FCS_OP_SHORTCUT_ON,
        FCS_OP_SHORTCUT_OFF,
        FCS_OP_RESET
    } fcs_op_t;

endpackage : fcs_pkg

// File: src/fcs_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-flop synchroniser for the data pins
// ----------------------------------------------------------------
module fcs_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    if (WIDTH < 1)
    begin : g_bad_width
        $error("sync width must be positive");
    end

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    // first stage is read only by the second
    always_comb
    begin
        meta_next = d_i;
        q_next = meta_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            meta_reg <= '0;
            q_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;

endmodule : fcs_sync

// File: src/fcs_host.sv
`timescale 1ns/1ps

// Operation
// - in shortcut mode a program takes two writes, else four.
// - while busy, reads give polling and toggle bits to watch.
// - the host may put the flash in standby via its controls.
// - chip select, write strobe, output enable avoid contention.
module fcs_host #(
    parameter int POLL_LIMIT = fcs_pkg::POLL_LIMIT_DEF,
    parameter logic [16:0] UNLOCK1_ADDR = 17'h00001,
    parameter logic [16:0] UNLOCK2_ADDR = 17'h00002,
    parameter logic [7:0] UNLOCK1_DATA = 8'h01,
    parameter logic [7:0] UNLOCK2_DATA = 8'h02,
    parameter logic [7:0] CMD_PROGRAM = 8'h10,
    parameter logic [7:0] CMD_ERASE_SETUP = 8'h20,
    parameter logic [7:0] CMD_SECTOR_ERASE = 8'h21,
    parameter logic [7:0] CMD_SUSPEND = 8'h30,
    parameter logic [7:0] CMD_RESUME = 8'h31,
    parameter logic [7:0] CMD_SHORTCUT_ON = 8'h40,
    parameter logic [7:0] CMD_SHORTCUT_OFF1 = 8'h41,
    parameter logic [7:0] CMD_SHORTCUT_OFF2 = 8'h42,
    parameter logic [7:0] CMD_RESET = 8'h50
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // user request
    input wire logic req_valid_i,
    input wire logic [2:0] req_op_i,
    input wire logic [16:0] req_addr_i,
    input wire logic [7:0] req_data_i,
    output logic req_ready_o,
    // user response
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic rsp_error_o,
    output logic shortcut_mode_o,
    // flash pins
    output logic [16:0] flash_addr_o,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe_o,
    input wire logic [7:0] flash_dq_i,
    output logic flash_ce_n_o,
    output logic flash_we_n_o,
    output logic flash_oe_n_o
);

    // ----------------------------------------------------------------
    // checks and types
    // ----------------------------------------------------------------
    if (POLL_LIMIT < 2 || POLL_LIMIT > 32'h7FFFFFFF)
    begin : g_bad_limit
        $error("poll limit out of range");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_WSET, ST_WLOW, ST_WEND, ST_RD, ST_DONE
    } fcs_state_t;

    localparam logic [7:0] RD_LAST = 8'(fcs_pkg::RD_CYC);
    localparam logic [7:0] WE_LAST = 8'(fcs_pkg::WE_CYC);
    localparam logic [31:0] POLL_MAX = 32'(POLL_LIMIT);

    logic [7:0] dq_sync;

    fcs_sync #(
        .WIDTH(fcs_pkg::DATA_W)
    ) u_dq_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .d_i(flash_dq_i),
        .q_o(dq_sync)
    );

    // ----------------------------------------------------------------
    // command sequence table: {last, addr, data} for step idx
    // ----------------------------------------------------------------
    function automatic logic [25:0] cmd_step(
        input fcs_pkg::fcs_op_t op,
        input logic [2:0] idx,
        input logic fast,
        input logic [16:0] a,
        input logic [7:0] d
    );
        logic [25:0] s;
        s = {1'b1, a, CMD_RESET};
        unique case (op)
            fcs_pkg::FCS_OP_PROGRAM:
                if (fast) // two writes in shortcut mode
                    s = (idx == 3'h0) ? {1'b0, a, CMD_PROGRAM}
                                      : {1'b1, a, d};
                else
                    unique case (idx)
                        3'h0: s = {1'b0, UNLOCK1_ADDR, UNLOCK1_DATA};
                        3'h1: s = {1'b0, UNLOCK2_ADDR, UNLOCK2_DATA};
                        3'h2: s = {1'b0, UNLOCK1_ADDR, CMD_PROGRAM};
                        default: s = {1'b1, a, d};
                    endcase
            fcs_pkg::FCS_OP_ERASE_SECTOR:
                unique case (idx)
                    3'h0, 3'h3: s = {1'b0, UNLOCK1_ADDR, UNLOCK1_DATA};
                    3'h1, 3'h4: s = {1'b0, UNLOCK2_ADDR, UNLOCK2_DATA};
                    3'h2: s = {1'b0, UNLOCK1_ADDR, CMD_ERASE_SETUP};
                    default: s = {1'b1, a, CMD_SECTOR_ERASE};
                endcase
            fcs_pkg::FCS_OP_SUSPEND: s = {1'b1, a, CMD_SUSPEND};
            fcs_pkg::FCS_OP_RESUME: s = {1'b1, a, CMD_RESUME};
            fcs_pkg::FCS_OP_SHORTCUT_ON:
                unique case (idx)
                    3'h0: s = {1'b0, UNLOCK1_ADDR, UNLOCK1_DATA};
                    3'h1: s = {1'b0, UNLOCK2_ADDR, UNLOCK2_DATA};
                    default: s = {1'b1, UNLOCK1_ADDR, CMD_SHORTCUT_ON};
                endcase
            fcs_pkg::FCS_OP_SHORTCUT_OFF:
                s = (idx == 3'h0) ? {1'b0, a, CMD_SHORTCUT_OFF1}
                                  : {1'b1, a, CMD_SHORTCUT_OFF2};
            default: s = {1'b1, a, CMD_RESET};
        endcase
        return s;
    endfunction : cmd_step

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    fcs_state_t state_reg, state_next;
    fcs_pkg::fcs_op_t op_reg, op_next;
    logic [16:0] addr_reg, addr_next;
    logic [7:0] data_reg, data_next;
    logic [2:0] idx_reg, idx_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [31:0] poll_reg, poll_next;
    logic prev_tog_reg, prev_tog_next;
    logic have_prev_reg, have_prev_next;
    logic fast_reg, fast_next;
    logic [7:0] rsp_data_reg, rsp_data_next;
    logic rsp_err_reg, rsp_err_next;
    logic [25:0] step;

    // next-state: write steps, polling reads, completion
    always_comb
    begin
        state_next = state_reg;
        op_next = op_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        idx_next = idx_reg;
        cnt_next = cnt_reg;
        poll_next = poll_reg;
        prev_tog_next = prev_tog_reg;
        have_prev_next = have_prev_reg;
        fast_next = fast_reg;
        rsp_data_next = rsp_data_reg;
        rsp_err_next = rsp_err_reg;
        step = cmd_step(op_reg, idx_reg, fast_reg, addr_reg, data_reg);
        unique case (state_reg)
            ST_IDLE: // taken only while ready is shown
                if (req_valid_i && req_ready_o)
                begin
                    op_next = fcs_pkg::fcs_op_t'(req_op_i);
                    addr_next = req_addr_i;
                    data_next = req_data_i;
                    idx_next = 3'h0;
                    cnt_next = 8'h00;
                    poll_next = 32'h0;
                    have_prev_next = 1'b0;
                    rsp_err_next = 1'b0;
                    state_next = (req_op_i == 3'(fcs_pkg::FCS_OP_READ))
                        ? ST_RD : ST_WSET;
                end
            ST_WSET:
            begin
                cnt_next = 8'h01;
                state_next = ST_WLOW;
            end
            ST_WLOW: // strobe held low for its least width
                if (cnt_reg >= WE_LAST)
                    state_next = ST_WEND;
                else
                    cnt_next = cnt_reg + 8'h01;
            ST_WEND:
            begin
                cnt_next = 8'h00;
                if (!step[25])
                begin
                    idx_next = idx_reg + 3'h1;
                    state_next = ST_WSET;
                end
                else if (op_reg == fcs_pkg::FCS_OP_PROGRAM ||
                         op_reg == fcs_pkg::FCS_OP_ERASE_SECTOR ||
                         op_reg == fcs_pkg::FCS_OP_SUSPEND)
                    state_next = ST_RD; // busy: poll
                else
                begin
                    if (op_reg == fcs_pkg::FCS_OP_SHORTCUT_ON)
                        fast_next = 1'b1;
                    else if (op_reg == fcs_pkg::FCS_OP_SHORTCUT_OFF ||
                             op_reg == fcs_pkg::FCS_OP_RESET)
                        fast_next = 1'b0;
                    state_next = ST_DONE;
                end
            end
            ST_RD:
                if (cnt_reg != RD_LAST)
                    cnt_next = cnt_reg + 8'h01;
                else if (op_reg == fcs_pkg::FCS_OP_READ)
                begin
                    rsp_data_next = dq_sync;
                    state_next = ST_DONE;
                end
                // toggle bit stable across two reads: done
                else if (have_prev_reg && (prev_tog_reg ==
                         dq_sync[fcs_pkg::TOGGLE_STATUS_POS]))
                begin
                    rsp_data_next = dq_sync;
                    // a refused program leaves the old byte behind
                    rsp_err_next = (op_reg == fcs_pkg::FCS_OP_PROGRAM)
                        && (dq_sync != data_reg);
                    state_next = ST_DONE;
                end
                else if (poll_reg >= POLL_MAX)
                begin
                    rsp_data_next = dq_sync;
                    rsp_err_next = 1'b1; // gave up waiting
                    state_next = ST_DONE;
                end
                else
                begin
                    prev_tog_next = dq_sync[fcs_pkg::TOGGLE_STATUS_POS];
                    have_prev_next = 1'b1;
                    poll_next = poll_reg + 32'h1;
                    cnt_next = 8'h00; // new read
                end
            ST_DONE:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= ST_IDLE;
            op_reg <= fcs_pkg::FCS_OP_READ;
            addr_reg <= 17'h00000;
            data_reg <= 8'h00;
            idx_reg <= 3'h0;
            cnt_reg <= 8'h00;
            poll_reg <= 32'h0;
            prev_tog_reg <= 1'b0;
            have_prev_reg <= 1'b0;
            fast_reg <= 1'b0;
            rsp_data_reg <= 8'h00;
            rsp_err_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            idx_reg <= idx_next;
            cnt_reg <= cnt_next;
            poll_reg <= poll_next;
            prev_tog_reg <= prev_tog_next;
            have_prev_reg <= have_prev_next;
            fast_reg <= fast_next;
            rsp_data_reg <= rsp_data_next;
            rsp_err_reg <= rsp_err_next;
        end
    end

    // ----------------------------------------------------------------
    // pin drive, all registered from the next state
    // ----------------------------------------------------------------
    logic ce_n_reg, ce_n_next;
    logic we_n_reg, we_n_next;
    logic oe_n_reg, oe_n_next;
    logic dq_oe_reg, dq_oe_next;
    logic [16:0] pin_addr_reg, pin_addr_next;
    logic [7:0] pin_dq_reg, pin_dq_next;
    logic ready_reg, ready_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [25:0] nstep;

    // oe only low a cycle after dq released, so no contention
    always_comb
    begin
        nstep = cmd_step(op_next, idx_next, fast_next, addr_next,
            data_next);
        // chip deselected between requests: standby
        ce_n_next = (state_next == ST_IDLE) || (state_next == ST_DONE);
        we_n_next = (state_next != ST_WLOW);
        oe_n_next = !((state_next == ST_RD) && (cnt_next != 8'h00));
        dq_oe_next = (state_next == ST_WSET) ||
            (state_next == ST_WLOW) || (state_next == ST_WEND);
        pin_addr_next = (state_next == ST_RD) ? addr_next
                                              : nstep[24:8];
        pin_dq_next = nstep[7:0];
        ready_next = (state_next == ST_IDLE);
        rsp_valid_next = (state_next == ST_DONE);
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            ce_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
            pin_addr_reg <= 17'h00000;
            pin_dq_reg <= 8'h00;
            ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
        end
        else
        begin
            ce_n_reg <= ce_n_next;
            we_n_reg <= we_n_next;
            oe_n_reg <= oe_n_next;
            dq_oe_reg <= dq_oe_next;
            pin_addr_reg <= pin_addr_next;
            pin_dq_reg <= pin_dq_next;
            ready_reg <= ready_next;
            rsp_valid_reg <= rsp_valid_next;
        end
    end

    assign flash_ce_n_o = ce_n_reg;
    assign flash_we_n_o = we_n_reg;
    assign flash_oe_n_o = oe_n_reg;
    assign flash_dq_oe_o = dq_oe_reg;
    assign flash_addr_o = pin_addr_reg;
    assign flash_dq_o = pin_dq_reg;
    assign req_ready_o = ready_reg;
    assign rsp_valid_o = rsp_valid_reg;
    assign rsp_data_o = rsp_data_reg;
    assign rsp_error_o = rsp_err_reg;
    assign shortcut_mode_o = fast_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [3:0] wcount_reg, wcount_next;

    // helper: write strobes issued for the current request
    always_comb
    begin
        wcount_next = wcount_reg;
        if (state_reg == ST_IDLE)
            wcount_next = 4'h0;
        else if (!we_n_next && we_n_reg)
            wcount_next = wcount_reg + 4'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            wcount_reg <= 4'h0;
        else
            wcount_reg <= wcount_next;
    end

    a_no_contention: assert property (@(posedge clk_i)
        disable iff (!reset_n_i) flash_dq_oe_o |-> flash_oe_n_o)
        else $error("data driven while output enable low");

    a_we_inside_ce: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && flash_dq_oe_o
            ##1 flash_dq_oe_o)
        else $error("write strobe outside select or data hold");

    a_idle_standby: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        req_ready_o |-> flash_ce_n_o && flash_we_n_o && flash_oe_n_o)
        else $error("chip selected while idle");

    a_program_length: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (state_reg == ST_DONE && op_reg == fcs_pkg::FCS_OP_PROGRAM)
        |-> wcount_reg == (fast_reg ? 4'h2 : 4'h4))
        else $error("program sequence has wrong write count");

    a_poll_before_done: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (rsp_valid_o && !rsp_error_o &&
         op_reg == fcs_pkg::FCS_OP_ERASE_SECTOR) |-> have_prev_reg)
        else $error("erase reported done without two polls");

    a_poll_read_gap: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        $rose(flash_oe_n_o) && state_reg == ST_RD |=>
            $fell(flash_oe_n_o))
        else $error("polling reads not separated by one cycle");

endmodule : fcs_host

// File: sim/fcs_flash_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// behavioural flash; command codes match the host's defaults
// ----------------------------------------------------------------
module fcs_flash_model #(
    parameter int PROG_CYC = 12,
    parameter int ERASE_CYC = 60,
    parameter int ERASE_LONG = 150,
    parameter int SLEEP_CYC = 20
) (
    // busy timing reference
    input wire logic clk_i,
    // flash pins
    input wire logic [16:0] addr_i,
    input wire logic [7:0] dq_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    output logic [7:0] dq_o,
    // fault controls
    input wire logic [7:0] prot_i,
    input wire logic low_vcc_i,
    input wire logic slow_i
);
    logic [7:0] mem [131072];
    logic [7:0] last = 8'h00;
    logic [7:0] la_d;
    logic [16:0] la_a;
    logic [2:0] esec = 3'h0;
    logic tog = 1'b0;
    logic fast = 1'b0;
    logic esetup = 1'b0;
    logic susp = 1'b0;
    logic pol = 1'b0;
    int busy = 0;
    int step = 0;
    int still = 0;
    logic [16:0] a_prev = 17'h00000;
    logic asleep;

    initial
    begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end

    // self-timed; a suspended erase holds until resumed
    always @(posedge clk_i)
        if (busy > 0 && !susp) busy <= busy - 1;

    // sleeps once the address stays put; data still served on wake
    always @(posedge clk_i)
    begin
        a_prev <= addr_i;
        if (addr_i != a_prev)
            still <= 0;
        else
            still <= still + 1;
    end
    assign asleep = (still >= SLEEP_CYC);

    // toggle flips on each read while busy and not suspended
    always @(negedge oe_n_i)
        if (!ce_n_i && busy > 0 && !susp) tog <= ~tog;

    // released bus shows the inverse, so a stale byte never passes
    always @(posedge oe_n_i) last <= dq_o;
    always @*
        if (!ce_n_i && !oe_n_i)
            dq_o = (busy > 0 && !susp) ? {~pol, tog, 6'h00}
                                       : mem[addr_i];
        else
            dq_o = ~last;

    // command decoder; each write with ce_n_i low and low_vcc_i clear latches address and data
    always @(posedge we_n_i)
    begin
        if (!ce_n_i && !low_vcc_i)
        begin
            la_a = addr_i;
            la_d = dq_i;
            if (busy > 0 && !susp)
                susp = (la_d == 8'h30);
            else if (step != 3 && la_d == 8'h50)
                step = 0;
            else if (susp && la_d == 8'h31)
                susp = 1'b0;
            else
                case (step)
                    0: step = (fast && la_d == 8'h10) ? 3 :
                              (fast && la_d == 8'h41) ? 5 :
                              (la_a == 17'h00001 && la_d == 8'h01) ? 1 : 0;
                    1: step = (la_a == 17'h00002 && la_d == 8'h02) ? 2 : 0;
                    2:
                    begin
                        step = (la_d == 8'h10) ? 3 : 0;
                        fast = fast | (la_d == 8'h40);
                        if (la_d == 8'h21 && esetup && !prot_i[la_a[16:14]])
                        begin
                            // erased to ones at once, others untouched
                            for (int i = 0; i < 16384; i++)
                                mem[{la_a[16:14], 14'h0000} + i] = 8'hFF;
                            esec = la_a[16:14];
                            pol = 1'b1;
                            busy = slow_i ? ERASE_LONG : ERASE_CYC;
                        end
                        esetup = (la_d == 8'h20);
                    end
                    3:
                    begin
                        step = 0;
                        if (!prot_i[la_a[16:14]] &&
                            !(susp && la_a[16:14] == esec))
                        begin
                            mem[la_a] = mem[la_a] & la_d;
                            pol = la_d[7];
                            if (!susp) busy = PROG_CYC;
                        end
                    end
                    default:
                    begin
                        fast = fast & (la_d != 8'h42);
                        step = 0;
                    end
                endcase
        end
    end
endmodule : fcs_flash_model

// File: sim/fcs_host_tb.sv
`timescale 1ns/1ps

module fcs_host_tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic [2:0] req_op_i = 3'h0;
    logic [16:0] req_addr_i = 17'h00000;
    logic [7:0] req_data_i = 8'h00;
    logic req_ready_o, rsp_valid_o, rsp_error_o, shortcut_mode_o;
    logic [7:0] rsp_data_o, flash_dq_o, mdq, dq_bus, got;
    logic [16:0] flash_addr_o;
    logic flash_dq_oe_o, flash_ce_n_o, flash_we_n_o, flash_oe_n_o, gerr;
    logic [7:0] prot = 8'h00;
    logic low_vcc = 1'b0;
    logic slow = 1'b0;
    int n_errors = 0;
    int checks_done = 0;
    int n_we = 0;
    int n_oe = 0;
    int cyc = 0;

    always #50 clk_i = ~clk_i;
    // wire level from both drivers
    assign dq_bus = flash_dq_oe_o ? flash_dq_o : mdq;

    fcs_host #(.POLL_LIMIT(20)) DUT (.clk_i, .reset_n_i, .req_valid_i,
        .req_op_i, .req_addr_i, .req_data_i, .req_ready_o, .rsp_valid_o,
        .rsp_data_o, .rsp_error_o, .shortcut_mode_o, .flash_addr_o,
        .flash_dq_o, .flash_dq_oe_o, .flash_dq_i(dq_bus), .flash_ce_n_o,
        .flash_we_n_o, .flash_oe_n_o);

    fcs_flash_model FLASH (.clk_i, .addr_i(flash_addr_o), .dq_i(dq_bus),
        .ce_n_i(flash_ce_n_o), .we_n_i(flash_we_n_o),
        .oe_n_i(flash_oe_n_o), .dq_o(mdq), .prot_i(prot),
        .low_vcc_i(low_vcc), .slow_i(slow));

    // strobe counters and hang guard, well above the ~1000 cycles used
    always @(negedge flash_we_n_o) n_we++;
    always @(negedge flash_oe_n_o) n_oe++;
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %0t: byte %h expected %h", $time, g, e);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic g, input logic e);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %0t: flag %b expected %b", $time, g, e);
        end
    endtask : chk_bit

    // one request, held until taken, then wait for its answer
    task automatic req(input logic [2:0] op, input logic [16:0] a,
                       input logic [7:0] d);
        int t;
        t = 0;
        @(negedge clk_i);
        while (req_ready_o !== 1'b1 && t < 400)
        begin
            @(negedge clk_i);
            t++;
        end
        req_op_i = op;
        req_addr_i = a;
        req_data_i = d;
        req_valid_i = 1'b1;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1 && t < 400)
        begin
            @(negedge clk_i);
            t++;
        end
        chk_bit(t < 400, 1'b1);
        got = rsp_data_o;
        gerr = rsp_error_o;
    endtask : req

    task automatic rd(input logic [16:0] a, input logic [7:0] e);
        req(3'h0, a, 8'h00);
        chk_byte(got, e);
    endtask : rd

    task automatic prog(input logic [16:0] a, input logic [7:0] d,
                        input logic e);
        req(3'h1, a, d);
        chk_bit(gerr, e);
    endtask : prog

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_program();
        chk_bit(flash_ce_n_o, 1'b1);
        chk_bit(flash_we_n_o, 1'b1);
        chk_bit(flash_oe_n_o, 1'b1);
        n_we = 0;
        n_oe = 0;
        prog(17'h04005, 8'hA5, 1'b0);
        chk_byte(8'(n_we), 8'h04);
        chk_bit(n_oe > 1, 1'b1);
        rd(17'h04005, 8'hA5);
        prog(17'h04005, 8'h0F, 1'b1);
        rd(17'h04005, 8'h05);
        prog(17'h1FFFF, 8'h81, 1'b0);
        rd(17'h1FFFF, 8'h81);
    endtask : t_program

    task automatic t_shortcut();
        req(3'h5, 17'h00000, 8'h00);
        chk_bit(shortcut_mode_o, 1'b1);
        n_we = 0;
        prog(17'h04010, 8'h3C, 1'b0);
        chk_byte(8'(n_we), 8'h02);
        rd(17'h04010, 8'h3C);
        req(3'h6, 17'h00000, 8'h00);
        chk_bit(shortcut_mode_o, 1'b0);
    endtask : t_shortcut

    task automatic t_erase();
        prog(17'h08000, 8'h55, 1'b0);
        prog(17'h0C000, 8'hAA, 1'b0);
        n_we = 0;
        req(3'h2, 17'h08000, 8'h00);
        chk_byte(8'(n_we), 8'h06);
        rd(17'h08000, 8'hFF);
        rd(17'h0C000, 8'hAA);
        rd(17'h04005, 8'h05);
    endtask : t_erase

    task automatic t_guard();
        prog(17'h14000, 8'h12, 1'b0);
        prot = 8'h20;
        req(3'h2, 17'h14000, 8'h00);
        rd(17'h14000, 8'h12);
        prog(17'h14001, 8'h34, 1'b1);
        rd(17'h14001, 8'hFF);
        prot = 8'h00;
        low_vcc = 1'b1;
        prog(17'h18000, 8'h77, 1'b1);
        rd(17'h18000, 8'hFF);
        low_vcc = 1'b0;
        prog(17'h18000, 8'h77, 1'b0);
    endtask : t_guard

    // a long erase outlasts the poll limit, so suspend meets it busy
    task automatic t_single();
        slow = 1'b1;
        req(3'h2, 17'h08000, 8'h00);
        slow = 1'b0;
        chk_bit(gerr, 1'b1);
        n_we = 0;
        req(3'h3, 17'h08000, 8'h00);
        chk_bit(gerr, 1'b0);
        rd(17'h18000, 8'h77);
        prog(17'h1C000, 8'h5A, 1'b0);
        rd(17'h1C000, 8'h5A);
        prog(17'h08001, 8'h11, 1'b1);
        req(3'h4, 17'h08000, 8'h00);
        req(3'h7, 17'h00000, 8'h00);
        chk_byte(8'(n_we), 8'h0B);
        repeat (80) @(negedge clk_i);
        chk_bit(FLASH.asleep, 1'b1);
        rd(17'h18000, 8'h77);
        rd(17'h08000, 8'hFF);
    endtask : t_single

    initial
    begin
        repeat (8) @(negedge clk_i);
        reset_n_i = 1'b1;
        t_program();
        t_shortcut();
        t_erase();
        t_guard();
        t_single();
        end_of_test();
    end
endmodule : fcs_host_tb
